// ==== verilog/mpc_pkg.sv ====
// constants, types and helper functions of the motor pwm core control block
package mpc_pkg;

  localparam int N_CH = 6; // pwm channels
  localparam int N_PAIR = 3; // complementary pairs
  localparam int CNT_W = 12; // counter and modulus width
  localparam int DUTY_W = 16; // signed duty value width
  localparam int BYTE_W = 8; // register data width
  localparam int ADR_W = 8; // wishbone byte address width
  localparam int WB_DW = 32; // wishbone data width
  localparam int SEL_W = 2; // prescale and load frequency fields
  localparam int DIV_W = 3; // divider counters, up to eight

  // register byte addresses, one aligned word each
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CFG = 8'h04;
  localparam logic [ADR_W-1:0] OFS_MODE = 8'h08;
  localparam logic [ADR_W-1:0] OFS_DEAD = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_MANUAL = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CNT_HI = 8'h14;
  localparam logic [ADR_W-1:0] OFS_CNT_LO = 8'h18;
  localparam logic [ADR_W-1:0] OFS_MOD_HI = 8'h1c;
  localparam logic [ADR_W-1:0] OFS_MOD_LO = 8'h20;
  localparam logic [ADR_W-1:0] OFS_DUTY_BASE = 8'h24; // high byte of channel 0
  localparam logic [ADR_W-1:0] DUTY_STRIDE = 8'h08; // per channel
  localparam logic [ADR_W-1:0] DUTY_LO_STEP = 8'h04; // low byte after high
  localparam logic [ADR_W-1:0] OFS_FAULT = 8'h54;

  // control register bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_LOAD_OK = 1;
  localparam int CTRL_RFLAG = 4;
  localparam int CTRL_IRQEN = 5;
  // config register fields
  localparam int CFG_PRSC_LSB = 0;
  localparam int CFG_LDFQ_LSB = 6;
  // mode register bits
  localparam int MODE_CENTER = 0;
  localparam int MODE_COMP = 1;
  localparam int MODE_ISENSE = 2;
  localparam int MODE_MANUAL = 3;
  localparam int MODE_CORR_LSB = 4;
  localparam logic [BYTE_W-1:0] MODE_MASK = 8'h7f; // bit 7 reserved
  // fault register bits
  localparam int FAULT_FLAG = 0;

  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;
  localparam logic [DIV_W-1:0] DIV_ONE = 3'h1;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ONE = 8'h01;

  // counter phase, gray along idle -> up -> down
  typedef enum logic [1:0] {
    MPC_IDLE = 2'b00,
    MPC_UP = 2'b01,
    MPC_DOWN = 2'b11
  } mpc_phase_t;

  // dead time inserter state of one pair
  typedef struct packed {
    logic tgt_top;
    logic tgt_bot;
    logic top;
    logic bot;
    logic [BYTE_W-1:0] elapsed;
    logic [BYTE_W-1:0] cap;
  } mpc_dt_t;

  // whole state of the core
  typedef struct packed {
    logic ack;
    logic [BYTE_W-1:0] rdat;
    logic en;
    logic load_ok;
    logic rflag;
    logic irq_en;
    logic armed;
    logic [BYTE_W-1:0] mode;
    logic [N_PAIR-1:0] corr_act;
    logic first;
    logic [BYTE_W-1:0] dead;
    logic dead_set;
    logic [N_CH-1:0] man;
    logic [SEL_W-1:0] ldfq_buf;
    logic [SEL_W-1:0] ldfq_act;
    logic [SEL_W-1:0] prsc_buf;
    logic [SEL_W-1:0] prsc_act;
    logic [CNT_W-1:0] mod_buf;
    logic [CNT_W-1:0] mod_act;
    logic [CNT_W-1:0] cnt;
    logic [N_CH-1:0][DUTY_W-1:0] duty_buf;
    logic [N_CH-1:0][DUTY_W-1:0] duty_act;
    mpc_phase_t phase;
    logic [DIV_W-1:0] presc;
    logic [DIV_W-1:0] ld;
    logic [BYTE_W-1:0] cnt_lo_latch;
    logic latched;
    logic fflag;
    logic fault_prev;
    logic [N_CH-1:0] gen_out;
    logic [N_CH-1:0] pin;
    logic [N_CH-1:0] oe;
    logic irq;
  } mpc_state_t;

  localparam mpc_state_t MPC_STATE_RST = '0;

  // last count of a divide by 1, 2, 4 or 8
  function automatic logic [DIV_W-1:0] mpc_div_last(input logic [SEL_W-1:0] sel);
    return DIV_W'((DIV_ONE << sel) - DIV_ONE);
  endfunction

  // byte address of a channel's duty high byte
  function automatic logic [ADR_W-1:0] mpc_duty_ofs(input int ch);
    return OFS_DUTY_BASE + ADR_W'(ch) * DUTY_STRIDE;
  endfunction

  // compare of one duty value against the counter
  function automatic logic mpc_duty_on(input logic [DUTY_W-1:0] duty,
                                       input logic [CNT_W-1:0] cnt,
                                       input logic [CNT_W-1:0] modv);
    if ($signed(duty) <= $signed(DUTY_W'(0))) return 1'b0;
    if (duty >= DUTY_W'(modv)) return 1'b1;
    return (cnt != CNT_ZERO) && (DUTY_W'(cnt) <= duty);
  endfunction

endpackage

// ==== verilog/mpc_dead_time.sv ====
// dead time inserter for one complementary output pair
`timescale 1ns/10ps
module mpc_dead_time
  import mpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_i, // freeze, debug halt or stop
  input wire logic comp_i, // complementary mode
  input wire logic [BYTE_W-1:0] dead_time_i, // cycles of the operating clock
  input wire logic top_i,
  input wire logic bot_i,
  output logic top_o,
  output logic bot_o
);

  mpc_dt_t q; // registered state
  mpc_dt_t d; // next state
  logic [BYTE_W-1:0] lim; // wait bound in force

  // the larger of captured and current value, so a change never shortens
  assign lim = (dead_time_i > q.cap) ? dead_time_i : q.cap;

  // next state
  always_comb begin
    d = q;
    if (!comp_i) begin
      // independent channels pass straight through
      d.top = top_i;
      d.bot = bot_i;
      d.tgt_top = top_i;
      d.tgt_bot = bot_i;
      d.elapsed = BYTE_ZERO;
    end else if ((top_i != q.tgt_top) || (bot_i != q.tgt_bot)) begin
      // an output turning off goes at once, one turning on waits
      d.tgt_top = top_i;
      d.tgt_bot = bot_i;
      d.top = q.top & top_i;
      d.bot = q.bot & bot_i;
      d.elapsed = BYTE_ZERO;
      d.cap = dead_time_i;
    end else if (q.elapsed >= lim) begin
      d.top = q.tgt_top;
      d.bot = q.tgt_bot;
    end else begin
      d.elapsed = q.elapsed + BYTE_ONE;
    end
    if (hold_i) begin
      d = q;
    end
    if (rst_i) begin
      d = '0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  assign top_o = q.top;
  assign bot_o = q.bot;

endmodule

// ==== verilog/mpc_core.sv ====
// motor pwm core control: counter, modulus, buffered duty values, enable and halt
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module mpc_core
  import mpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  output logic [WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fault_i, // high means fault, inactive forcing
  input wire logic debug_halt_i, // debug halt state of the cpu
  input wire logic halt_clear_enable_i, // lets flags clear during halt
  input wire logic stop_i, // stop mode, all module clocks stopped
  output logic [N_CH-1:0] pwm_o, // pin levels
  output logic [N_CH-1:0] pwm_oe_o, // pin drive enables
  output logic irq_o // reload or fault interrupt request
);

  mpc_state_t q; // registered state
  mpc_state_t d; // next state
  logic acc; // bus access accepted this cycle
  logic wr; // write to the low byte lane
  logic rd; // read
  logic [BYTE_W-1:0] wv; // written byte
  logic run; // generator and output control clocked
  logic clr_ok; // flags may be cleared
  logic tick; // prescaled counter clock
  logic cyc_end; // last count of a pwm cycle
  logic reload_ev; // reload cycle begins
  logic comp; // complementary mode
  logic [N_PAIR-1:0] pair_top; // requested top levels
  logic [N_PAIR-1:0] pair_bot; // requested bottom levels
  logic [N_PAIR-1:0] dt_top; // top levels after dead time
  logic [N_PAIR-1:0] dt_bot; // bottom levels after dead time

  assign comp = q.mode[MODE_COMP];
  // wait mode needs nothing: all clocks keep running there
  assign run = ~stop_i & ~debug_halt_i;
  assign clr_ok = ~debug_halt_i | halt_clear_enable_i;

  // pair sources: manual levels or generator outputs
  always_comb begin
    for (int p = 0; p < N_PAIR; p++) begin
      if (q.mode[MODE_MANUAL]) begin
        pair_top[p] = q.man[2*p];
        pair_bot[p] = q.man[2*p+1];
      end else if (comp) begin
        pair_top[p] = q.gen_out[2*p];
        pair_bot[p] = ~q.gen_out[2*p] & q.en;
      end else begin
        pair_top[p] = q.gen_out[2*p];
        pair_bot[p] = q.gen_out[2*p+1];
      end
    end
  end

  // one dead time inserter per pair, kept running while disabled
  for (genvar gp = 0; gp < N_PAIR; gp++) begin : g_pair
    mpc_dead_time u_dt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .hold_i(~run),
      .comp_i(comp),
      .dead_time_i(q.dead),
      .top_i(pair_top[gp]),
      .bot_i(pair_bot[gp]),
      .top_o(dt_top[gp]),
      .bot_o(dt_bot[gp])
    );
  end

  // bus decode, register file, generator and pin stage
  always_comb begin
    d = q;
    acc = wb_cyc_i & wb_stb_i & ~q.ack;
    wr = acc & wb_we_i & wb_sel_i[0];
    rd = acc & ~wb_we_i;
    wv = wb_dat_i[BYTE_W-1:0];
    tick = 1'b0;
    cyc_end = 1'b0;
    reload_ev = 1'b0;
    d.ack = acc; // one wait state, answer in the next cycle

    // read data, unmapped addresses read zero
    d.rdat = BYTE_ZERO;
    case (wb_adr_i)
      OFS_CTRL: begin
        d.rdat[CTRL_EN] = q.en;
        d.rdat[CTRL_LOAD_OK] = q.load_ok;
        d.rdat[CTRL_RFLAG] = q.rflag;
        d.rdat[CTRL_IRQEN] = q.irq_en;
      end
      OFS_CFG: begin
        d.rdat[CFG_PRSC_LSB +: SEL_W] = q.prsc_buf; // buffer, not active
        d.rdat[CFG_LDFQ_LSB +: SEL_W] = q.ldfq_buf;
      end
      OFS_MODE: d.rdat = q.mode;
      OFS_DEAD: d.rdat = q.dead;
      OFS_MANUAL: d.rdat = BYTE_W'(q.man);
      OFS_CNT_HI: d.rdat = BYTE_W'(q.cnt[CNT_W-1:BYTE_W]);
      OFS_CNT_LO: d.rdat = q.latched ? q.cnt_lo_latch : q.cnt[BYTE_W-1:0];
      OFS_MOD_HI: d.rdat = BYTE_W'(q.mod_buf[CNT_W-1:BYTE_W]);
      OFS_MOD_LO: d.rdat = q.mod_buf[BYTE_W-1:0];
      OFS_FAULT: d.rdat[FAULT_FLAG] = q.fflag;
      default: begin
        for (int i = 0; i < N_CH; i++) begin
          if (wb_adr_i == mpc_duty_ofs(i)) begin
            d.rdat = q.duty_buf[i][DUTY_W-1:BYTE_W];
          end
          if (wb_adr_i == mpc_duty_ofs(i) + DUTY_LO_STEP) begin
            d.rdat = q.duty_buf[i][BYTE_W-1:0];
          end
        end
      end
    endcase

    // read side effects
    if (rd && (wb_adr_i == OFS_CTRL) && q.rflag) begin
      d.armed = 1'b1; // first step of the flag clear
    end
    if (rd && (wb_adr_i == OFS_CNT_HI)) begin
      d.cnt_lo_latch = q.cnt[BYTE_W-1:0];
      d.latched = 1'b1;
    end
    if (rd && (wb_adr_i == OFS_CNT_LO)) begin
      d.latched = 1'b0;
    end

    // register writes
    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          d.en = wv[CTRL_EN];
          d.load_ok = wv[CTRL_LOAD_OK];
          d.irq_en = wv[CTRL_IRQEN];
          if (!wv[CTRL_RFLAG] && q.armed && clr_ok) begin
            d.rflag = 1'b0;
            d.armed = 1'b0;
          end
        end
        OFS_CFG: begin
          d.prsc_buf = wv[CFG_PRSC_LSB +: SEL_W];
          d.ldfq_buf = wv[CFG_LDFQ_LSB +: SEL_W];
        end
        OFS_MODE: d.mode = wv & MODE_MASK;
        OFS_DEAD: begin
          // write once until the next reset
          if (!q.dead_set) begin
            d.dead = wv;
            d.dead_set = 1'b1;
          end
        end
        OFS_MANUAL: d.man = wv[N_CH-1:0];
        OFS_MOD_HI: d.mod_buf[CNT_W-1:BYTE_W] = wv[CNT_W-BYTE_W-1:0];
        OFS_MOD_LO: d.mod_buf[BYTE_W-1:0] = wv;
        OFS_FAULT: begin
          if (wv[FAULT_FLAG] && clr_ok) begin
            d.fflag = 1'b0;
          end
        end
        default: begin
          for (int i = 0; i < N_CH; i++) begin
            if (wb_adr_i == mpc_duty_ofs(i)) begin
              d.duty_buf[i][DUTY_W-1:BYTE_W] = wv;
            end
            if (wb_adr_i == mpc_duty_ofs(i) + DUTY_LO_STEP) begin
              d.duty_buf[i][BYTE_W-1:0] = wv;
            end
          end
        end
      endcase
    end

    // generator
    if (!d.en) begin
      // flag and interrupt request are left alone here
      d.phase = MPC_IDLE;
      d.cnt = CNT_ZERO;
      d.presc = DIV_ZERO;
      d.ld = DIV_ZERO;
      d.gen_out = '0;
    end else if (run) begin
      if (q.phase == MPC_IDLE) begin
        // start: immediate reload, first cycle follows
        reload_ev = 1'b1;
        d.phase = MPC_UP;
        d.cnt = CNT_ZERO;
        d.first = 1'b1;
        d.corr_act = q.mode[MODE_CORR_LSB +: N_PAIR];
      end else begin
        tick = (q.presc == mpc_div_last(q.prsc_act));
        d.presc = tick ? DIV_ZERO : q.presc + DIV_ONE;
        if (tick) begin
          if (q.mod_act == CNT_ZERO) begin
            // illegal modulus, endless count down from the top
            d.cnt = q.cnt - CNT_ONE;
            cyc_end = (q.cnt == CNT_ZERO);
          end else if (!q.mode[MODE_CENTER]) begin
            // edge aligned: 1 .. modulus, period equals modulus
            cyc_end = (q.cnt >= q.mod_act);
            d.cnt = cyc_end ? CNT_ONE : q.cnt + CNT_ONE;
          end else if (q.phase == MPC_UP) begin
            // center aligned: up to modulus then down, twice the period
            if (q.cnt >= q.mod_act) begin
              d.phase = MPC_DOWN;
              d.cnt = q.cnt - CNT_ONE;
            end else begin
              d.cnt = q.cnt + CNT_ONE;
            end
          end else begin
            cyc_end = (q.cnt <= CNT_ONE);
            d.cnt = cyc_end ? CNT_ZERO : q.cnt - CNT_ONE;
            if (cyc_end) begin
              d.phase = MPC_UP;
            end
          end
        end
        if (cyc_end) begin
          d.first = 1'b0;
          d.corr_act = q.mode[MODE_CORR_LSB +: N_PAIR];
          // load divider counts pwm cycles between reloads
          if (q.ld == mpc_div_last(q.ldfq_act)) begin
            reload_ev = 1'b1;
            d.ld = DIV_ZERO;
          end else begin
            d.ld = q.ld + DIV_ONE;
          end
        end
      end
      // duty compare, in complementary mode pairs share their selected value
      for (int i = 0; i < N_CH; i++) begin
        if (comp) begin
          d.gen_out[i] = mpc_duty_on(q.duty_act[2*(i/2) + int'(q.corr_act[i/2] &
            ~(q.first & q.mode[MODE_ISENSE]))], q.cnt, q.mod_act);
        end else begin
          d.gen_out[i] = mpc_duty_on(q.duty_act[i], q.cnt, q.mod_act);
        end
      end
    end

    // reload: load frequency buffer always, other buffers when allowed, flag always
    if (reload_ev) begin
      d.ldfq_act = d.ldfq_buf;
      if (d.load_ok) begin
        d.mod_act = d.mod_buf;
        d.prsc_act = d.prsc_buf;
        d.duty_act = d.duty_buf;
        d.load_ok = 1'b0;
      end
      // without load ok the last loaded modulus stays in force
      d.rflag = 1'b1;
      d.armed = 1'b0; // a reload between read and write spoils the clear
    end

    // fault section, clocked in halt too; stop freezes it
    if (!stop_i) begin
      d.fault_prev = fault_i;
      if (fault_i && !q.fault_prev) begin
        d.fflag = 1'b1; // set wins over a clear
      end
    end

    // pin stage
    if (run) begin
      for (int p = 0; p < N_PAIR; p++) begin
        d.pin[2*p] = dt_top[p];
        d.pin[2*p+1] = dt_bot[p];
      end
      d.oe = (d.en | d.mode[MODE_MANUAL]) ? '1 : '0;
    end
    if (fault_i) begin
      d.pin = '0;
    end
    d.irq = (d.rflag & d.irq_en) | d.fflag;

    if (rst_i) begin
      // modulus registers are deliberately not reset
      d = MPC_STATE_RST;
      d.mod_buf = q.mod_buf;
      d.mod_act = q.mod_act;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // outputs straight from the state register
  assign wb_dat_o = WB_DW'(q.rdat);
  assign wb_ack_o = q.ack;
  assign pwm_o = q.pin;
  assign pwm_oe_o = q.oe;
  assign irq_o = q.irq;

endmodule

// ==== tb/mpc_core_assertions.sv ====
// concurrent checks on the ports of the motor pwm core
`timescale 1ns/10ps
module mpc_core_assertions
  import mpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  input wire logic [WB_DW-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic fault_i,
  input wire logic debug_halt_i,
  input wire logic halt_clear_enable_i,
  input wire logic stop_i,
  input wire logic [N_CH-1:0] pwm_o,
  input wire logic [N_CH-1:0] pwm_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req; // request taken at this edge
  logic ctl_wr; // control byte written
  logic man_q; // mirror of manual output select
  logic comp_q; // mirror of complementary mode
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctl_wr = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_CTRL);
  // manual select decides whether disable floats the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      man_q <= 1'b0;
      comp_q <= 1'b0;
    end else if (req && wb_we_i && wb_sel_i[0] && (wb_adr_i == OFS_MODE)) begin
      man_q <= wb_dat_i[MODE_MANUAL];
      comp_q <= wb_dat_i[MODE_COMP];
    end
  end
  // pairs never both on once complementary mode has reached the pins
  AST_PAIR_EXCL: assert property (comp_q && $past(comp_q, 3) |-> !((pwm_o[0] && pwm_o[1])
    || (pwm_o[2] && pwm_o[3]) || (pwm_o[4] && pwm_o[5]))) else $error("pair both on");
  AST_ACK_NEXT: assert property (req |=> wb_ack_o)
    else $error("request left without ack");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[WB_DW-1:BYTE_W] == '0)
    else $error("upper read data not zero");
  AST_OE_UNIFORM: assert property (pwm_oe_o == '0 || pwm_oe_o == '1)
    else $error("pin enables disagree");
  AST_EN_DRIVES: assert property (ctl_wr && wb_dat_i[CTRL_EN] && !debug_halt_i && !stop_i
    |-> ##[1:4] pwm_oe_o == '1) else $error("enable did not drive pins");
  AST_DIS_FLOAT: assert property (ctl_wr && !wb_dat_i[CTRL_EN] && !man_q && !debug_halt_i
    && !stop_i |-> ##[1:4] pwm_oe_o == '0) else $error("disable did not float pins");
  AST_FAULT_FORCE: assert property (fault_i && !stop_i |=> pwm_o == '0)
    else $error("fault did not force pins low");
  AST_HALT_HOLD: assert property (debug_halt_i && !fault_i && !$past(fault_i)
    |=> $stable(pwm_o) && $stable(pwm_oe_o)) else $error("pins moved in halt");
  AST_STOP_HOLD: assert property (stop_i |=> $stable(pwm_o) && $stable(pwm_oe_o))
    else $error("pins moved in stop");
  AST_FAULT_IRQ: assert property ($rose(fault_i) && !stop_i |-> ##[1:3] irq_o)
    else $error("fault raised no request");
  // main scenarios reached
  cover property (ctl_wr && wb_dat_i[CTRL_EN]);
  cover property (debug_halt_i && fault_i);
  cover property (stop_i && pwm_oe_o == '1);
  cover property (comp_q && pwm_o[0]);
endmodule
bind mpc_core mpc_core_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fault_i(fault_i),
  .debug_halt_i(debug_halt_i), .halt_clear_enable_i(halt_clear_enable_i), .stop_i(stop_i),
  .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o), .irq_o(irq_o));

// ==== tb/mpc_gate_drv.sv ====
// power stage gate driver model on the pwm pins
`timescale 1ns/10ps
module mpc_gate_drv
  import mpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic stop_i,
  input wire logic [N_CH-1:0] pwm_i,
  input wire logic [N_CH-1:0] oe_i,
  output logic [N_CH-1:0] gate_o,
  output logic [7:0] toggles_o
);
  logic [N_CH-1:0] last_q; // gate level one cycle ago
  logic [7:0] tog_q = 8'h00; // gate changes seen in stop, single driver
  // pull-downs hold a floating pin off
  assign gate_o = pwm_i & oe_i;
  assign toggles_o = tog_q;
  // switching in stop could wreck the stage, so count it
  always @(posedge clk_i) begin
    if (stop_i && gate_o !== last_q) tog_q <= tog_q + 8'h01;
    last_q <= gate_o;
  end
endmodule

// ==== tb/mpc_core_tb.sv ====
// self-checking testbench of the motor pwm core
`timescale 1ns/10ps
module mpc_core_tb;
  import mpc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, fault, halt, hce, stop, ack, irq;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [WB_DW-1:0] wdat, rdat;
  logic [N_CH-1:0] pwm, oe, gate;
  logic [7:0] toggles, rd; // rd: last read byte
  int miscompares = 0;
  int checks = 0;
  mpc_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fault_i(fault), .debug_halt_i(halt), .halt_clear_enable_i(hce), .stop_i(stop),
    .pwm_o(pwm), .pwm_oe_o(oe), .irq_o(irq));
  mpc_gate_drv drv (.clk_i(clk_i), .stop_i(stop), .pwm_i(pwm), .oe_i(oe), .gate_o(gate),
    .toggles_o(toggles));
  // 20 mhz operating clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // whole run needs about 3000 cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end
  task automatic wrap_up;
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, data taken at the ack edge
  task automatic bus(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      wrap_up();
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rchk(input logic [ADR_W-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  // poll control until the reload flag shows
  task automatic poll_flag(output time t);
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_CTRL, 8'h00);
      n++;
    end while (rd[CTRL_RFLAG] !== 1'b1 && n < 400);
    chk(rd[CTRL_RFLAG], 1'b1);
    t = $time;
  endtask
  task automatic wait_load;
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_CTRL, 8'h00);
      n++;
    end while (rd[CTRL_LOAD_OK] !== 1'b0 && n < 400);
    chk(rd[CTRL_LOAD_OK], 1'b0);
    repeat (4) @(posedge clk_i);
  endtask
  // period and high time, from a rise after at least 8 low cycles
  task automatic per(input int ch, input int ep, input int eh);
    int p, h, lo, st;
    p = 0;
    h = 0;
    lo = 0;
    st = 0;
    for (int i = 0; i < 3000 && st < 2; i++) begin
      @(posedge clk_i);
      if (lo >= 8 && pwm[ch] === 1'b1) st++;
      lo = (pwm[ch] === 1'b0) ? lo + 1 : 0;
      if (st == 1) begin
        p++;
        h += (pwm[ch] === 1'b1);
      end
    end
    chk(p, ep);
    chk(h, eh);
  endtask
  // reset values, unmapped place, buffers written and read back
  task automatic t_regs;
    for (int c = 0; c < N_CH; c++) begin
      rchk(OFS_DUTY_BASE + ADR_W'(8 * c), 8'h00);
      rchk(OFS_DUTY_BASE + ADR_W'(8 * c + 4), 8'h00);
    end
    bus(1'b1, 8'h80, 8'h5a);
    rchk(8'h80, 8'h00);
    bus(1'b1, OFS_MOD_LO, 8'h40);
    bus(1'b1, OFS_MOD_HI, 8'h00);
    bus(1'b1, OFS_DUTY_BASE + 8'h04, 8'h04);
    bus(1'b1, OFS_DUTY_BASE + 8'h0c, 8'h40);
    bus(1'b1, OFS_DUTY_BASE + 8'h10, 8'hff);
    bus(1'b1, OFS_DUTY_BASE + 8'h14, 8'hff);
    rchk(OFS_MOD_LO, 8'h40);
    rchk(OFS_DUTY_BASE + 8'h0c, 8'h40);
  endtask
  // first enable with no load, disable, enable with load
  task automatic t_first;
    bus(1'b1, OFS_CTRL, 8'h21);
    rchk(OFS_CTRL, 8'h31);
    chk(irq, 1'b1);
    repeat (4) @(posedge clk_i);
    chk(oe, 6'h3f);
    repeat (70) begin
      @(posedge clk_i);
      if (pwm !== 6'h00) chk(pwm, 6'h00);
    end
    bus(1'b1, OFS_CTRL, 8'h30);
    repeat (4) @(posedge clk_i);
    rchk(OFS_CTRL, 8'h30);
    chk(irq, 1'b1);
    chk(oe, 6'h00);
    rchk(OFS_CNT_HI, 8'h00);
    bus(1'b1, OFS_CTRL, 8'h23);
    rchk(OFS_CNT_LO, 8'h00);
    wait_load();
  endtask
  // loaded duties in edge mode: off, on, period
  task automatic t_edge;
    repeat (70) begin
      @(posedge clk_i);
      if (pwm[2:1] !== 2'b01) chk(pwm[2:1], 2'b01);
    end
    per(0, 64, 4);
  endtask
  // center mode with prescale of 2
  task automatic t_center;
    bus(1'b1, OFS_MODE, 8'h01);
    bus(1'b1, OFS_CFG, 8'h01);
    bus(1'b1, OFS_CTRL, 8'h23);
    wait_load();
    per(0, 256, 16);
  endtask
  // flag clear sequence and reload every 8 periods
  task automatic t_flag;
    time t0, t1;
    bus(1'b1, OFS_MODE, 8'h00);
    bus(1'b1, OFS_CFG, 8'hc0);
    bus(1'b1, OFS_CTRL, 8'h23);
    wait_load();
    bus(1'b1, OFS_CTRL, 8'h21);
    rchk(OFS_CTRL, 8'h21);
    poll_flag(t0);
    bus(1'b1, OFS_CTRL, 8'h21);
    poll_flag(t1);
    chk((t1 - t0) / 50 inside {[508:516]}, 1'b1);
    repeat (520) @(posedge clk_i);
    bus(1'b1, OFS_CTRL, 8'h21);
    rchk(OFS_CTRL, 8'h31);
  endtask
  // complementary pair shares duty 0, dead time delays each turn-on
  task automatic t_comp;
    int h;
    bus(1'b1, OFS_DEAD, 8'h01);
    bus(1'b1, OFS_DEAD, 8'h05);
    rchk(OFS_DEAD, 8'h01);
    bus(1'b1, OFS_MODE, 8'h02);
    per(0, 64, 2);
    h = 0;
    repeat (64) begin
      @(posedge clk_i);
      h += (pwm[1] === 1'b1);
    end
    chk(h, 58);
  endtask
  // halt freezes pins, fault still forces, flag clear gated
  task automatic t_halt;
    logic [N_CH-1:0] held;
    halt <= 1'b1;
    repeat (3) @(posedge clk_i);
    held = pwm;
    repeat (20) @(posedge clk_i);
    chk(pwm, held);
    fault <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(pwm, 6'h00);
    bus(1'b1, OFS_FAULT, 8'h01);
    rchk(OFS_FAULT, 8'h01);
    hce <= 1'b1;
    bus(1'b1, OFS_FAULT, 8'h01);
    rchk(OFS_FAULT, 8'h00);
    fault <= 1'b0;
    hce <= 1'b0;
    halt <= 1'b0;
  endtask
  // disabled with manual levels, then stop
  task automatic t_manual;
    bus(1'b1, OFS_MODE, 8'h08);
    bus(1'b1, OFS_MANUAL, 8'h2a);
    bus(1'b1, OFS_CTRL, 8'h20);
    repeat (4) @(posedge clk_i);
    chk(oe, 6'h3f);
    chk(gate, 6'h2a);
    stop <= 1'b1;
    repeat (30) @(posedge clk_i);
    stop <= 1'b0;
    chk(toggles, 8'h00);
  endtask
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, fault, halt, hce, stop} = '0;
    sel = 4'h1;
    adr = '0;
    wdat = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_first();
    t_edge();
    t_center();
    t_flag();
    t_comp();
    t_halt();
    t_manual();
    wrap_up();
  end
endmodule
